// [common/sram_sleep_consts.vh]
// constants shared by the pipelined sram cycle and sleep control
`ifndef SRAM_SLEEP_CONSTS_VH
`define SRAM_SLEEP_CONSTS_VH

// ****************************************************************
// geometry defaults
// ****************************************************************
`define SRAM_ADDR_W          17
`define SRAM_DATA_W          36
`define SRAM_BYTES           4

// ****************************************************************
// pin encodings
// ****************************************************************
`define BURST_LINEAR         1'b0
`define BURST_INTERLEAVED    1'b1
`define ADV_LOAD             1'b0
`define RW_READ              1'b1
`define SEL_N_ACTIVE         1'b0
`define SEL_ACTIVE           1'b1
`define BURST_CNT_W          2

// ****************************************************************
// sleep timing, in clock periods
// ****************************************************************
`define SLEEP_ENTRY_MAX_PERIODS 2
`define SLEEP_EXIT_MAX_PERIODS  2
`define SLEEP_ENTRY_MAX_CYC     (`SLEEP_ENTRY_MAX_PERIODS * 1)
`define SLEEP_EXIT_MAX_CYC      (`SLEEP_EXIT_MAX_PERIODS * 1)

`endif

// [logic/sram_pipe_array.v]
// byte-lane storage array with synchronous write and combinational read
`timescale 1ns/10ps
module sram_pipe_array #(
    parameter ADDR_W = 17,
    parameter DATA_W = 36,
    parameter BYTES  = 4
) (
    input  wire              i_mclk,
    input  wire              i_we,
    input  wire [ADDR_W-1:0] i_waddr,
    input  wire [DATA_W-1:0] i_wdata,
    input  wire [BYTES-1:0]  i_wbe_n,
    input  wire [ADDR_W-1:0] i_raddr,
    output wire [DATA_W-1:0] o_rdata
);
    localparam LANE_W = DATA_W / BYTES;
    localparam DEPTH  = 1 << ADDR_W;

    genvar b;
    generate
        for (b = 0; b < BYTES; b = b + 1) begin : g_lane
            reg [LANE_W-1:0] lane_mem [0:DEPTH-1];
            always @(posedge i_mclk) begin
                if (i_we && !i_wbe_n[b]) begin
                    lane_mem[i_waddr] <= i_wdata[b*LANE_W +: LANE_W];
                end
            end
            assign o_rdata[b*LANE_W +: LANE_W] = lane_mem[i_raddr];
        end
    endgenerate
endmodule // sram_pipe_array

// [logic/pipelined_sram_sleep_cycle_ctrl.v]
// pipelined sram front end: select decode, bursts, stalls, coherency, sleep
// Function
// - while the sleep request is high the device sleeps and counts as deselected.
// - the sleep request is an active-high input acting without any qualifying command.
// - asleep, every input but the sleep request is ignored and data outputs go high-z.
// - synchronous inputs stop being honoured at most two clocks after sleep rises.
// - synchronous inputs are sampled again at most two clocks after sleep falls.
// - burst order comes from the order pin, 0 linear and 1 interleaved.
// - selected only when primary select_n is 0, secondary select_n is 0, select is 1.
// - a high clock gate ignores the edge and holds the whole pipeline.
// - no array write happens on an edge ignored by the clock gate.
// - reads return the newest data, forwarded from arriving or pending write data if needed.
`timescale 1ns/10ps
`include "sram_sleep_consts.vh"
module pipelined_sram_sleep_cycle_ctrl #(
    parameter ADDR_W = `SRAM_ADDR_W,
    parameter DATA_W = `SRAM_DATA_W,
    parameter BYTES  = `SRAM_BYTES
) (
    input  wire              i_mclk,
    input  wire              i_rst,
    input  wire              i_sleep_request,
    input  wire              i_burst_order,
    input  wire              i_oe_n,
    input  wire              i_clock_gate_n,
    input  wire              i_sel_n,
    input  wire              i_secondary_select_n,
    input  wire              i_secondary_select,
    input  wire              i_adv_ld,
    input  wire              i_rw,
    input  wire [BYTES-1:0]  i_bw_n,
    input  wire [ADDR_W-1:0] i_addr,
    input  wire [DATA_W-1:0] i_dq_in,
    output reg  [DATA_W-1:0] o_dq_out,
    output reg               o_dq_oe_n,
    output reg               o_sleeping
);
    localparam LANE_W = DATA_W / BYTES;
    localparam CW     = `BURST_CNT_W;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg zz_meta;
    reg zz_sync;
    reg oe_meta_n;
    reg oe_sync_n;
    reg mode_meta;
    reg mode_sync;

    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            zz_meta   <= 1'b0;
            zz_sync   <= 1'b0;
            oe_meta_n <= 1'b1;
            oe_sync_n <= 1'b1;
            mode_meta <= `BURST_LINEAR;
            mode_sync <= `BURST_LINEAR;
        end else begin
            zz_meta   <= i_sleep_request;
            zz_sync   <= zz_meta;
            oe_meta_n <= i_oe_n;
            oe_sync_n <= oe_meta_n;
            mode_meta <= i_burst_order;
            mode_sync <= mode_meta;
        end
    end

    // ****************************************************************
    // pipeline state
    // ****************************************************************
    reg              s1_valid;
    reg              s1_write;
    reg [ADDR_W-1:0] s1_addr;
    reg [BYTES-1:0]  s1_bw_n;
    reg              s2_valid;
    reg              s2_write;
    reg [ADDR_W-1:0] s2_addr;
    reg [BYTES-1:0]  s2_bw_n;
    reg              pend_valid;
    reg [ADDR_W-1:0] pend_addr;
    reg [DATA_W-1:0] pend_data;
    reg [BYTES-1:0]  pend_bw_n;
    reg [ADDR_W-1:0] burst_base;
    reg [CW-1:0]     burst_cnt;
    reg              last_valid;
    reg              last_write;
    reg [DATA_W-1:0] rd_data;
    reg              rd_valid;
    reg              drive;

    wire selected = (i_sel_n == `SEL_N_ACTIVE) &&
                    (i_secondary_select_n == `SEL_N_ACTIVE) &&
                    (i_secondary_select == `SEL_ACTIVE);
    wire step     = !i_clock_gate_n && !zz_sync;

    // ****************************************************************
    // next command: load or burst continue
    // ****************************************************************
    reg              next_valid;
    reg              next_write;
    reg [ADDR_W-1:0] next_addr;
    reg [ADDR_W-1:0] next_base;
    reg [CW-1:0]     next_cnt;
    reg [BYTES-1:0]  next_bw_n;
    reg [CW-1:0]     next_low;

    always @* begin
        next_valid = last_valid;
        next_write = last_write;
        next_base  = burst_base;
        next_cnt   = burst_cnt + {{(CW-1){1'b0}}, 1'b1};
        next_bw_n  = i_bw_n;
        next_low   = {CW{1'b0}};
        if (i_adv_ld == `ADV_LOAD) begin
            next_valid = selected;
            next_write = (i_rw != `RW_READ);
            next_base  = i_addr;
            next_cnt   = {CW{1'b0}};
        end
        if (mode_sync == `BURST_INTERLEAVED) begin
            next_low = next_base[CW-1:0] ^ next_cnt;
        end else begin
            next_low = next_base[CW-1:0] + next_cnt;
        end
        next_addr = {next_base[ADDR_W-1:CW], next_low};
    end

    // ****************************************************************
    // storage and read merge
    // ****************************************************************
    wire [DATA_W-1:0] arr_rdata;
    wire [DATA_W-1:0] merged;
    wire              arr_we   = step && pend_valid;
    wire              s2_hit   = s2_valid && s2_write && (s2_addr == s1_addr);
    wire              pend_hit = pend_valid && (pend_addr == s1_addr);

    sram_pipe_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .BYTES  (BYTES)
    ) u_array (
        .i_mclk  (i_mclk),
        .i_we    (arr_we),
        .i_waddr (pend_addr),
        .i_wdata (pend_data),
        .i_wbe_n (pend_bw_n),
        .i_raddr (s1_addr),
        .o_rdata (arr_rdata)
    );

    genvar b;
    generate
        for (b = 0; b < BYTES; b = b + 1) begin : g_merge
            // newest first: data arriving now, then the pending write, then the array
            assign merged[b*LANE_W +: LANE_W] =
                (s2_hit && !s2_bw_n[b])     ? i_dq_in[b*LANE_W +: LANE_W]   :
                (pend_hit && !pend_bw_n[b]) ? pend_data[b*LANE_W +: LANE_W] :
                                              arr_rdata[b*LANE_W +: LANE_W];
        end
    endgenerate

    wire next_drive = zz_sync ? 1'b0 : (step ? rd_valid : drive);

    // ****************************************************************
    // pipeline advance
    // ****************************************************************
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_valid   <= 1'b0;
            s1_write   <= 1'b0;
            s1_addr    <= {ADDR_W{1'b0}};
            s1_bw_n    <= {BYTES{1'b1}};
            s2_valid   <= 1'b0;
            s2_write   <= 1'b0;
            s2_addr    <= {ADDR_W{1'b0}};
            s2_bw_n    <= {BYTES{1'b1}};
            pend_valid <= 1'b0;
            pend_addr  <= {ADDR_W{1'b0}};
            pend_data  <= {DATA_W{1'b0}};
            pend_bw_n  <= {BYTES{1'b1}};
            burst_base <= {ADDR_W{1'b0}};
            burst_cnt  <= {CW{1'b0}};
            last_valid <= 1'b0;
            last_write <= 1'b0;
            rd_data    <= {DATA_W{1'b0}};
            rd_valid   <= 1'b0;
            drive      <= 1'b0;
            o_dq_out   <= {DATA_W{1'b0}};
            o_dq_oe_n  <= 1'b1;
            o_sleeping <= 1'b0;
        end else begin
            o_sleeping <= zz_sync;
            o_dq_oe_n  <= zz_sync || oe_sync_n || !next_drive;
            drive      <= next_drive;
            if (zz_sync) begin
                // abandon everything in flight and look deselected
                s1_valid   <= 1'b0;
                s2_valid   <= 1'b0;
                pend_valid <= 1'b0;
                last_valid <= 1'b0;
                rd_valid   <= 1'b0;
            end else if (step) begin
                s1_valid   <= next_valid;
                s1_write   <= next_write;
                s1_addr    <= next_addr;
                s1_bw_n    <= next_bw_n;
                burst_base <= next_base;
                burst_cnt  <= next_cnt;
                last_valid <= next_valid;
                last_write <= next_write;
                s2_valid   <= s1_valid;
                s2_write   <= s1_write;
                s2_addr    <= s1_addr;
                s2_bw_n    <= s1_bw_n;
                pend_valid <= s2_valid && s2_write;
                if (s2_valid && s2_write) begin
                    pend_addr <= s2_addr;
                    pend_data <= i_dq_in;
                    pend_bw_n <= s2_bw_n;
                end
                rd_valid   <= s1_valid && !s1_write;
                if (s1_valid && !s1_write) begin
                    rd_data <= merged;
                end
                if (rd_valid) begin
                    o_dq_out <= rd_data;
                end
            end
        end
    end
endmodule // pipelined_sram_sleep_cycle_ctrl

// [testbench/sram_ctrl_properties.sv]
// port-level checks on the pipelined sram front end
`timescale 1ns/10ps
module sram_ctrl_properties #(
    parameter DATA_W = 36
) (
    input wire              i_mclk,
    input wire              i_rst,
    input wire              i_sleep_request,
    input wire              i_oe_n,
    input wire              i_clock_gate_n,
    input wire              i_sel_n,
    input wire              i_secondary_select_n,
    input wire              i_secondary_select,
    input wire              i_adv_ld,
    input wire              i_rw,
    input wire [DATA_W-1:0] o_dq_out,
    input wire              o_dq_oe_n,
    input wire              o_sleeping
);
    wire sel_ok = !i_sel_n && !i_secondary_select_n && i_secondary_select;
    wire calm   = !i_clock_gate_n && !i_sleep_request && !o_sleeping && !i_adv_ld;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_hiz; o_sleeping |-> o_dq_oe_n; endproperty
    a_hiz: assert property (p_hiz) else $error("data driven while asleep");
    property p_entry; $rose(i_sleep_request) |-> ##[1:3] o_sleeping; endproperty
    a_entry: assert property (p_entry) else $error("sleep entry late");
    property p_level; i_sleep_request [*4] |-> o_sleeping; endproperty
    a_level: assert property (p_level) else $error("awake under sleep request");
    property p_exit; $fell(i_sleep_request) |-> ##[1:3] !o_sleeping; endproperty
    a_exit: assert property (p_exit) else $error("sleep exit late");
    property p_wake; $fell(o_sleeping) |-> o_dq_oe_n ##1 o_dq_oe_n; endproperty
    a_wake: assert property (p_wake) else $error("drive right after wake");
    property p_stall; i_clock_gate_n && !i_sleep_request && !o_sleeping |=> $stable(o_dq_out);
    endproperty
    a_stall: assert property (p_stall) else $error("data moved on gated edge");
    property p_desel;
        (calm && !sel_ok) ##1 !i_clock_gate_n [*2] |=> o_dq_oe_n;
    endproperty
    a_desel: assert property (p_desel) else $error("drive after deselect");
    property p_read;
        (calm && sel_ok && i_rw && !i_oe_n) ##1 (!i_clock_gate_n && !i_sleep_request) [*2]
        |=> !o_dq_oe_n;
    endproperty
    a_read: assert property (p_read) else $error("read not driven");
endmodule // sram_ctrl_properties
bind pipelined_sram_sleep_cycle_ctrl sram_ctrl_properties #(.DATA_W(DATA_W)) u_props (
    .i_mclk               (i_mclk),
    .i_rst                (i_rst),
    .i_sleep_request      (i_sleep_request),
    .i_oe_n               (i_oe_n),
    .i_clock_gate_n       (i_clock_gate_n),
    .i_sel_n              (i_sel_n),
    .i_secondary_select_n (i_secondary_select_n),
    .i_secondary_select   (i_secondary_select),
    .i_adv_ld             (i_adv_ld),
    .i_rw                 (i_rw),
    .o_dq_out             (o_dq_out),
    .o_dq_oe_n            (o_dq_oe_n),
    .o_sleeping           (o_sleeping)
);

// [testbench/sram_ctrl_model.sv]
// command-side model of the memory controller feeding the sram
`timescale 1ns/10ps
module sram_ctrl_model (
    input  wire        i_mclk,
    output reg         o_gate_n,
    output reg         o_adv_ld,
    output reg         o_rw,
    output reg  [2:0]  o_sel,
    output reg  [3:0]  o_addr,
    output reg  [35:0] o_wdata
);
    reg [35:0] w1, w2;
    initial begin
        {o_gate_n, o_adv_ld, o_rw, o_sel, o_addr} = 10'h0e0;
        {o_wdata, w1, w2} = 108'h0;
    end
    // one cycle; write data follows two enabled edges later
    task cyc(input g, a, r, input [2:0] s, input [3:0] ad, input [35:0] d);
        begin
            @(posedge i_mclk);
            #1;
            {o_gate_n, o_adv_ld, o_rw, o_addr} = {g, a, r, ad};
            o_sel = s;
            if (!g) begin
                o_wdata = w2;
                w2 = w1;
                w1 = r ? ~w1 : d;
            end
        end
    endtask
endmodule // sram_ctrl_model

// [testbench/tb.sv]
// self-checking bench for the pipelined sram front end
`timescale 1ns/10ps
module tb;
    reg         i_mclk, i_rst, i_sleep_request, i_burst_order, i_oe_n;
    wire        gate_n, adv, rw, o_dq_oe_n, o_sleeping;
    wire [2:0]  sel;
    wire [3:0]  addr;
    wire [35:0] wdata, o_dq_out;
    integer     miscompares, n_tests, k, o, x;
    sram_ctrl_model m (.i_mclk(i_mclk), .o_gate_n(gate_n), .o_adv_ld(adv), .o_rw(rw),
        .o_sel(sel), .o_addr(addr), .o_wdata(wdata));
    pipelined_sram_sleep_cycle_ctrl #(.ADDR_W(4)) dut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_sleep_request(i_sleep_request), .i_burst_order(i_burst_order), .i_oe_n(i_oe_n),
        .i_clock_gate_n(gate_n), .i_sel_n(sel[2]), .i_secondary_select_n(sel[1]),
        .i_secondary_select(sel[0]), .i_adv_ld(adv), .i_rw(rw), .i_bw_n(4'h0),
        .i_addr(addr), .i_dq_in(wdata), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
        .o_sleeping(o_sleeping));
    task chk(input [63:0] nm, input [35:0] e, g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("unexpected %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task dsl(input integer n);
        repeat (n) m.cyc(0, 0, 1, 3'b110, 4'h0, 36'h0);
    endtask
    task wr(input [3:0] a, input [35:0] d);
        m.cyc(0, 0, 0, 3'b001, a, d);
    endtask
    task rd(input [3:0] a, input [35:0] e);
        begin
            m.cyc(0, 0, 1, 3'b001, a, 36'h0);
            dsl(3);
            chk("rdata", e, o_dq_out);
            chk("drive", 36'h0, {35'h0, o_dq_oe_n});
            dsl(1);
            chk("release", 36'h1, {35'h0, o_dq_oe_n});
        end
    endtask
    task t_fwd;
        begin
            wr(4'h1, 36'h9a5a5a5a5);
            rd(4'h1, 36'h9a5a5a5a5);
            $display("t_fwd done");
        end
    endtask
    task t_stall;
        begin
            wr(4'h3, 36'h0aa);
            m.cyc(1, 0, 0, 3'b001, 4'h1, 36'h055);
            m.cyc(1, 0, 0, 3'b001, 4'h1, 36'h055);
            rd(4'h3, 36'h0aa);
            rd(4'h1, 36'h9a5a5a5a5);
            // read held one extra edge in the pipeline by a pause
            m.cyc(0, 0, 1, 3'b001, 4'h3, 36'h0);
            dsl(1);
            m.cyc(1, 0, 1, 3'b110, 4'h0, 36'h0);
            dsl(1);
            chk("paused", 36'h1, {35'h0, o_dq_oe_n});
            dsl(1);
            chk("resumed", 36'h0aa, o_dq_out);
            chk("res_drv", 36'h0, {35'h0, o_dq_oe_n});
            $display("t_stall done");
        end
    endtask
    task t_sel;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                if (k != 1) begin
                    m.cyc(0, 0, 1, k[2:0], 4'h1, 36'h0);
                    dsl(3);
                    chk("desel", 36'h1, {35'h0, o_dq_oe_n});
                end
            end
            $display("t_sel done");
        end
    endtask
    task t_burst;
        begin
            for (o = 0; o < 2; o = o + 1) begin
                i_burst_order = o[0];
                for (k = 4; k < 8; k = k + 1)
                    wr(k[3:0], 36'h100 + k + 16 * o);
                dsl(2);
                m.cyc(0, 0, 1, 3'b001, 4'h5, 36'h0);
                for (k = 0; k < 6; k = k + 1) begin
                    m.cyc(0, k < 3, 1, k < 3 ? 3'b001 : 3'b110, 4'h0, 36'h0);
                    x = o ? 1 ^ (k - 2) : (k - 1) & 3;
                    if (k > 1)
                        chk("burst", 36'h104 + 16 * o + x, o_dq_out);
                end
                dsl(1);
            end
            $display("t_burst done");
        end
    endtask
    task t_sleep;
        begin
            wr(4'h8, 36'h0c3);
            dsl(4);
            i_sleep_request = 1;
            dsl(3);
            chk("asleep", 36'h1, {35'h0, o_sleeping});
            chk("hiz", 36'h1, {35'h0, o_dq_oe_n});
            wr(4'h8, 36'h03c);
            dsl(3);
            i_sleep_request = 0;
            dsl(3);
            chk("awake", 36'h0, {35'h0, o_sleeping});
            chk("wake_hiz", 36'h1, {35'h0, o_dq_oe_n});
            rd(4'h8, 36'h0c3);
            $display("t_sleep done");
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        i_mclk = 0;
        forever #20 i_mclk = ~i_mclk;
    end
    initial begin
        {i_rst, i_sleep_request, i_burst_order, i_oe_n} = 4'h8;
        miscompares = 0;
        n_tests = 0;
        repeat (3) @(posedge i_mclk);
        #1 i_rst = 0;
        t_fwd;
        t_stall;
        t_sel;
        t_burst;
        t_sleep;
        close_out;
    end
    initial begin
        #100000;
        miscompares = miscompares + 1;
        close_out;
    end
endmodule // tb
